// ---- verilog/spi_master_map.svh ----
// offsets, field positions, reset values and timing counts of the serial master
`ifndef SPI_MASTER_MAP_SVH
`define SPI_MASTER_MAP_SVH
`define REG_CTRL 4'h0
`define REG_STATUS 4'h1
`define REG_MASK 4'h2
`define REG_WORDS 4'h3
`define REG_TXDATA 4'h4
`define REG_RXDATA 4'h5
`define REG_DIV 4'h6
`define CTRL_MODE_LO 0
`define CTRL_BITS_LO 4
`define CTRL_NSLV_LO 8
`define CTRL_STEP_BIT 12
`define ST_VALID_BIT 0
`define ST_OVERRUN_BIT 1
`define ST_BUSY_BIT 2
`define DIV_RESET 16'h0004
`define BITS_RESET 4'h7
`endif

// ---- verilog/spi_master_pkg.sv ----
// types shared by the serial master
package spi_master_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SETUP = 2'b01,
    ST_SHIFT = 2'b10,
    ST_GAP = 2'b11
  } state_e;
  typedef struct packed {
    logic [3:0] addr;
    logic read;
    logic write;
    logic [31:0] wdata;
  } bus_req_s;
  typedef struct packed {
    logic clk;
    logic mosi;
  } link_out_s;
endpackage : spi_master_pkg

// ---- verilog/spi_master.sv ----
// multi-slave serial master with avalon register slave
//
// Functional notes
// - word length 1..16 bits, divisor sets rate
// - one select line per slave
// - selects active low
// - master alone drives shift clock
// - pulse count per step matches words*bits
// - shift on one edge, capture opposite
// - phase 1 presents data half cycle early
// - one slave per step, successive steps
// - full duplex per slave, wrap after last
// - valid once all slaves served
// - transmit vector ordered slave by slave
// - receive vector ordered same as transmit
// - step during transfer raises overrun
// - polarity selects idle clock level
// - mode 0..3 maps polarity/phase table
// - word count per slave separately set
//
// The placing of the registers and register access over Avalon-MM were left to the implementer.
`timescale 1ns/10ps
`include "spi_master_map.svh"
module spi_master #(
  parameter int NSLV = 4, // number of slave selects
  parameter int MAXW = 4, // words per slave max
  parameter int TOTW = 16 // total word buffer depth
) (
  input wire logic SYS_CLK, // system clock 100 MHz
  input wire logic RESET_N, // async active low reset
  input wire logic [3:0] ADDRESS, // word address
  input wire logic READ, // read strobe
  input wire logic WRITE, // write strobe
  input wire logic [31:0] WRITEDATA, // write data
  output logic [31:0] READDATA, // read data, registered
  output logic WAITREQUEST, // wait request
  output logic IRQ, // level interrupt
  output logic SHIFT_CLOCK, // shift clock to slaves
  output logic SERIAL_OUT_TO_SLAVE, // data to slaves
  input wire logic SERIAL_IN_FROM_SLAVE, // data from slaves
  output logic [NSLV-1:0] SLAVE_SELECT_N // per slave selects, active low
);
  // the packed word-count register holds four 4-bit fields, so at most four
  // slaves can be sequenced whatever NSLV says; TOTW bounds the sum of counts
  // and a larger sum wraps the buffer index silently
  localparam int IW = $clog2(TOTW); // buffer index width

  // word count of slave s from packed word register
  // slave 0 sits in the lowest nibble
  function automatic logic [3:0] words_of(input logic [31:0] w, input logic [1:0] s);
    words_of = w[s*4 +: 4];
  endfunction : words_of

  // start index of slave s in the concatenated vector
  // summed over the lower slaves only; an 8-bit accumulator holds the
  // worst case of three full counts without wrapping
  function automatic logic [IW-1:0] base_of(input logic [31:0] w, input logic [1:0] s);
    logic [7:0] acc;
    acc = 8'h00;
    for (int i = 0; i < 4; i++) begin
      if (2'(i) < s) acc = acc + {4'h0, w[i*4 +: 4]};
    end
    base_of = acc[IW-1:0];
  endfunction : base_of

  // storage and sequencer state; data-carrying outputs leave from registers
  // so the pins never glitch between edges
  spi_master_pkg::bus_req_s req; // bundled request
  spi_master_pkg::link_out_s lo_r; // registered link outputs
  spi_master_pkg::state_e state_r; // sequencer state
  logic [31:0] ctrl_r; // mode, bits, slave count
  logic [31:0] words_r; // per-slave word counts, 4 bits each
  logic [15:0] div_r; // half period in sys clocks
  logic [2:0] stat_r; // sticky valid/overrun, busy live
  logic [2:0] mask_r; // interrupt mask
  logic [15:0] txmem [TOTW]; // transmit words
  logic [15:0] rxmem [TOTW]; // receive words
  logic [IW-1:0] ptr_r; // software buffer pointer
  logic [1:0] slv_r; // current slave
  logic [IW-1:0] widx_r; // current word index
  logic [3:0] wcnt_r; // words left for this slave
  logic [4:0] bit_r; // bits left in word
  logic [15:0] sh_r; // shift register
  logic [15:0] cnt_r; // half period counter
  logic half_r; // 0 = leading half, 1 = trailing
  logic [NSLV-1:0] sel_n_r; // select register
  logic miso_s1_r; // sync stage 1
  logic miso_s2_r; // sync stage 2
  logic [31:0] rdata_r; // read data register
  logic ack_r; // answer cycle marker

  // bundle the bus pins once so every decoder below reads the same fields
  assign req = '{addr: ADDRESS, read: READ, write: WRITE, wdata: WRITEDATA};

  // decoded fields
  wire [1:0] mode = ctrl_r[`CTRL_MODE_LO +: 2];
  wire cpol = mode[1];
  wire cpha = ~mode[0];
  wire [3:0] bits_m1 = ctrl_r[`CTRL_BITS_LO +: 4];
  wire [1:0] nslv_m1 = ctrl_r[`CTRL_NSLV_LO +: 2];
  // a write lands at the edge where the master sees waitrequest low
  wire wr_take = req.write && ack_r; // write completes in the answer cycle
  wire rd_take = req.read && ~ack_r; // read data latched one cycle ahead of the answer
  wire step_wr = wr_take && req.addr == `REG_CTRL && req.wdata[`CTRL_STEP_BIT];
  wire busy = state_r != spi_master_pkg::ST_IDLE;
  wire [3:0] cur_words = words_of(words_r, slv_r);
  // one tick per half period of the shift clock
  wire tick = cnt_r == 16'h0000;
  wire last_bit = bit_r == 5'h01;
  wire last_word = wcnt_r == 4'h1;
  wire last_slave = slv_r == nslv_m1;
  wire step_done = state_r == spi_master_pkg::ST_GAP && tick;
  // status events, one bit per sticky flag
  wire ev_valid = step_done && last_slave;
  wire ev_overrun = step_wr && busy;
  wire [2:0] ev = {1'b0, ev_overrun, ev_valid};
  wire [2:0] st_view = {busy, stat_r[1:0]};
  wire clr_wr = wr_take && req.addr == `REG_STATUS;
  wire [15:0] rx_sample = {sh_r[14:0], miso_s2_r};
  wire [15:0] width_mask = 16'hffff >> (4'hf - bits_m1); // keeps the configured word length
  wire [15:0] rx_word = (cpha ? sh_r : rx_sample) & width_mask;
  // data goes out on leading edge when phase 0, half cycle early when phase 1
  wire lead_edge = state_r == spi_master_pkg::ST_SHIFT && tick && ~half_r;
  wire trail_edge = state_r == spi_master_pkg::ST_SHIFT && tick && half_r;

  // pins: waitrequest is the only output that follows the request directly,
  // the interrupt is a plain function of registered state
  assign WAITREQUEST = (req.read || req.write) && ~ack_r; // one wait cycle per access
  assign READDATA = rdata_r;
  assign IRQ = |(stat_r[1:0] & mask_r[1:0]);
  assign SHIFT_CLOCK = lo_r.clk;
  assign SERIAL_OUT_TO_SLAVE = lo_r.mosi;
  assign SLAVE_SELECT_N = sel_n_r;

  // input synchroniser, second stage only is read
  // the slave answers on edges of our shift clock, so its data is not
  // aligned to SYS_CLK; two stages cost two cycles of latency, which is
  // why a divisor of one or two leaves too little margin for capture
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      miso_s1_r <= 1'b0;
      miso_s2_r <= 1'b0;
    end else begin
      miso_s1_r <= SERIAL_IN_FROM_SLAVE;
      miso_s2_r <= miso_s1_r;
    end
  end

  // bus answer: registered, one cycle after request seen
  // waitrequest drops in the second cycle of every access; read data is
  // latched in the first cycle so it already stands at the edge where the
  // master sees waitrequest low, and the receive port pointer advances
  // exactly once per read access
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ack_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
    end else begin
      ack_r <= (req.read || req.write) && ~ack_r;
      if (rd_take) begin
        case (req.addr)
          `REG_CTRL: rdata_r <= {19'h0, 1'b0, ctrl_r[11:0]};
          `REG_STATUS: rdata_r <= {29'h0, st_view};
          `REG_MASK: rdata_r <= {29'h0, mask_r};
          `REG_WORDS: rdata_r <= words_r;
          `REG_TXDATA: rdata_r <= {16'h0, txmem[ptr_r]};
          `REG_RXDATA: rdata_r <= {16'h0, rxmem[ptr_r]};
          `REG_DIV: rdata_r <= {16'h0, div_r};
          default: rdata_r <= 32'h0000_0000; // unmapped reads zero
        endcase
      end
    end
  end

  // configuration registers and buffer pointer
  // writes land only at the edge where waitrequest is low, so a master that
  // holds its request through the answer cycle never lands a write twice;
  // the divisor refuses zero because a zero half period would wrap the
  // counter reload to 16'hffff and stretch every phase to 65536 clocks
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ctrl_r <= {20'h0, 2'b00, 2'b00, `BITS_RESET, 4'h0};
      words_r <= 32'h0000_1111;
      div_r <= `DIV_RESET;
      mask_r <= 3'h0;
      ptr_r <= '0;
    end else if (wr_take) begin
      case (req.addr)
        `REG_CTRL: ctrl_r <= {20'h0, req.wdata[11:0]};
        `REG_MASK: mask_r <= req.wdata[2:0];
        `REG_WORDS: words_r <= req.wdata;
        `REG_DIV: div_r <= (req.wdata[15:0] == 16'h0000) ? 16'h0001 : req.wdata[15:0];
        // the pointer is shared: software rewinds it through the receive port
        `REG_TXDATA: ptr_r <= ptr_r + IW'(1);
        `REG_RXDATA: ptr_r <= req.wdata[IW-1:0]; // writing rx port sets pointer
        default: ;
      endcase
    end else if (rd_take && req.addr == `REG_RXDATA) begin
      ptr_r <= ptr_r + IW'(1);
    end
  end

  // transmit buffer, written in slave-by-slave order
  // no reset on the buffers: they are plain storage that software fills
  // before a step; a step on an unfilled buffer sends whatever is there
  always_ff @(posedge SYS_CLK) begin
    if (wr_take && req.addr == `REG_TXDATA) txmem[ptr_r] <= req.wdata[15:0];
  end

  // receive buffer, each word stored at its concatenated index
  // the word is trimmed to the configured length so stale transmit bits
  // left in the upper part of the shift register never reach software
  always_ff @(posedge SYS_CLK) begin
    if (trail_edge && last_bit) rxmem[widx_r] <= rx_word;
  end

  // sticky status: set beats clear
  // valid and overrun are cleared by writing one; an event in the same
  // cycle as its clear is kept, so software never loses an event that
  // lands while it is acknowledging the previous one
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) stat_r <= 3'h0;
    else stat_r <= (stat_r & ~(clr_wr ? req.wdata[2:0] : 3'h0)) | ev;
  end

  // sequencer: one slave per step, then advance and wrap
  // the half period counter runs free and is reloaded when a step begins,
  // so every phase of a step lasts exactly div_r system clocks; setup keeps
  // the select low one half period before the first edge, and the gap keeps
  // it low one half period after the last one, which gives a phase 1 slave
  // time to present its first bit and a phase 0 slave time to take its last
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state_r <= spi_master_pkg::ST_IDLE;
      slv_r <= 2'b00;
      widx_r <= '0;
      wcnt_r <= 4'h0;
      bit_r <= 5'h00;
      sh_r <= 16'h0000;
      cnt_r <= 16'h0000;
      half_r <= 1'b0;
      sel_n_r <= '1;
      // shift clock parks low until idle reads the polarity
      lo_r <= '{clk: 1'b0, mosi: 1'b0};
    end else begin
      cnt_r <= tick ? div_r - 16'h0001 : cnt_r - 16'h0001;
      case (state_r)
        // idle: clock parked at the polarity level, every select high
        spi_master_pkg::ST_IDLE: begin
          lo_r.clk <= cpol;
          sel_n_r <= '1;
          if (step_wr) begin // a step while busy is refused, only flagged
            state_r <= spi_master_pkg::ST_SETUP;
            widx_r <= base_of(words_r, slv_r);
            wcnt_r <= cur_words;
            cnt_r <= div_r - 16'h0001;
          end
        end
        // setup: select the slave and present the first bit
        spi_master_pkg::ST_SETUP: if (tick) begin
          sel_n_r <= ~(NSLV'(1) << slv_r);
          sh_r <= txmem[widx_r] << (4'hf - bits_m1);
          lo_r.mosi <= txmem[widx_r][bits_m1]; // msb first
          bit_r <= {1'b0, bits_m1} + 5'h01;
          half_r <= 1'b0;
          state_r <= (wcnt_r == 4'h0) ? spi_master_pkg::ST_GAP : spi_master_pkg::ST_SHIFT;
        end
        // shift: one clock toggle per half period
        spi_master_pkg::ST_SHIFT: if (tick) begin
          lo_r.clk <= ~lo_r.clk;
          half_r <= ~half_r;
          if (lead_edge) begin
            // phase 1: leading edge captures; phase 0: leading edge presents the bit
            if (cpha) sh_r <= rx_sample;
            else lo_r.mosi <= sh_r[15];
          end else begin
            if (!cpha) sh_r <= rx_sample;
            bit_r <= bit_r - 5'h01;
            if (last_bit) begin
              if (last_word) state_r <= spi_master_pkg::ST_GAP;
              else begin
                widx_r <= widx_r + IW'(1);
                wcnt_r <= wcnt_r - 4'h1;
                sh_r <= txmem[widx_r + IW'(1)] << (4'hf - bits_m1);
                lo_r.mosi <= txmem[widx_r + IW'(1)][bits_m1];
                bit_r <= {1'b0, bits_m1} + 5'h01;
              end
            end else if (cpha) lo_r.mosi <= sh_r[15];
          end
        end
        // gap: release the select and move to the next slave
        spi_master_pkg::ST_GAP: if (tick) begin
          sel_n_r <= '1;
          slv_r <= last_slave ? 2'b00 : slv_r + 2'b01;
          state_r <= spi_master_pkg::ST_IDLE;
        end
        default: state_r <= spi_master_pkg::ST_IDLE;
      endcase
    end
  end
endmodule : spi_master

// ---- verification/spi_master_monitor.sv ----
// concurrent checks on the pins of the serial master
`timescale 1ns/10ps
module spi_master_monitor #(
  parameter int NSLV = 4 // number of selects
) (
  input wire logic SYS_CLK, // system clock
  input wire logic RESET_N, // async reset, active low
  input wire logic [3:0] ADDRESS, // word address
  input wire logic READ, // read strobe
  input wire logic WRITE, // write strobe
  input wire logic [31:0] WRITEDATA, // write data
  input wire logic [31:0] READDATA, // read data
  input wire logic WAITREQUEST, // wait request
  input wire logic IRQ, // level interrupt
  input wire logic SHIFT_CLOCK, // shift clock
  input wire logic SERIAL_OUT_TO_SLAVE, // data to slaves
  input wire logic SERIAL_IN_FROM_SLAVE, // data from slaves
  input wire logic [NSLV-1:0] SLAVE_SELECT_N // selects, active low
);
  int edge_cnt; // clock toggles inside the current select window
  logic lvl_r; // clock level last seen while nobody was selected
  // count toggles per window; idle level is remembered while deselected
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      edge_cnt <= 0;
      lvl_r <= 1'b0;
    end else if (&SLAVE_SELECT_N) begin
      edge_cnt <= 0;
      lvl_r <= SHIFT_CLOCK;
    end else if (SHIFT_CLOCK != $past(SHIFT_CLOCK)) begin
      edge_cnt <= edge_cnt + 1;
    end
  end
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RESET_N);
  one_select_a: assert property ($onehot0(~SLAVE_SELECT_N))
    else $error("two selects low");
  wait_first_a: assert property ($rose(READ || WRITE) |-> WAITREQUEST)
    else $error("no wait in first request cycle");
  answer_next_a: assert property ((READ || WRITE) && WAITREQUEST |=> !WAITREQUEST)
    else $error("answer late");
  // outside a window the clock may only move one or two cycles after a bus write
  clock_still_a: assert property ($changed(SHIFT_CLOCK) && (&SLAVE_SELECT_N) && $past(RESET_N, 2)
    |-> $past(WRITE) || $past(WRITE, 2)) else $error("clock moved while idle");
  pulse_even_a: assert property ($rose(&SLAVE_SELECT_N) |-> !edge_cnt[0] && edge_cnt <= 480)
    else $error("partial pulse in window");
  idle_back_a: assert property ($rose(&SLAVE_SELECT_N) |-> SHIFT_CLOCK == lvl_r)
    else $error("clock not idle at deselect");
  select_lead_a: assert property ($fell(&SLAVE_SELECT_N) |-> $stable(SHIFT_CLOCK))
    else $error("clock moved with select");
  select_gap_a: assert property ($rose(&SLAVE_SELECT_N) |=> &SLAVE_SELECT_N)
    else $error("no gap between selects");
  cover property ($fell(SLAVE_SELECT_N[0]));
  cover property ($fell(SLAVE_SELECT_N[NSLV-1]));
  cover property ($rose(IRQ));
endmodule : spi_master_monitor
bind spi_master spi_master_monitor #(.NSLV(NSLV)) i_spi_master_monitor (.SYS_CLK, .RESET_N, .ADDRESS, .READ,
  .WRITE, .WRITEDATA, .READDATA, .WAITREQUEST, .IRQ, .SHIFT_CLOCK, .SERIAL_OUT_TO_SLAVE, .SERIAL_IN_FROM_SLAVE,
  .SLAVE_SELECT_N);

// ---- verification/spi_slave_model.sv ----
// behavioural serial slave: counting reply, collects what the master sends
`timescale 1ns/10ps
module spi_slave_model (
  input wire logic sel_n, // select, active low
  input wire logic sclk, // shift clock, only read here
  input wire logic mosi, // data from master
  input wire logic cpol, // idle clock level
  input wire logic cpha, // 1: data ahead of first edge
  input wire logic [4:0] bits, // word length
  input wire logic [15:0] base, // first reply word
  output logic miso, // data to master
  output logic [15:0] got // bits taken in
);
  logic [15:0] tx; // reply word in flight
  logic drv = 1'b0; // bit being presented
  int i; // bit index
  // a released line shows the inverse so a stale bit cannot pass
  assign miso = sel_n ? ~drv : drv;
  always @(negedge sel_n) begin
    tx = base;
    i = bits - 1;
    if (cpha) drv = tx[i];
  end
  // capture on one edge, present the next bit on the other
  always @(sclk) begin
    if (!sel_n && (sclk != cpol) == cpha) begin
      got = {got[14:0], mosi};
      i--;
      if (i < 0) begin
        tx = tx + 16'h0001;
        i = bits - 1;
      end
    end else if (!sel_n) begin
      drv = tx[i];
    end
  end
endmodule : spi_slave_model

// ---- verification/multi_slave_spi_master_tb.sv ----
// bench: register bus stimulus against two slave models
`timescale 1ns/10ps
`include "spi_master_map.svh"
module multi_slave_spi_master_tb;
  logic SYS_CLK = 0, RESET_N = 0, READ = 0, WRITE = 0, SERIAL_IN_FROM_SLAVE, cpol, cpha;
  logic [3:0] ADDRESS = 4'h0;
  logic [31:0] WRITEDATA = 32'h0000_0000, READDATA, q, ctrl, mask, got, tw [3];
  logic WAITREQUEST, IRQ, SHIFT_CLOCK, SERIAL_OUT_TO_SLAVE;
  logic [1:0] SLAVE_SELECT_N, miso;
  logic [4:0] bits;
  int failures = 0, checks = 0, edges = 0;
  always #5 SYS_CLK = ~SYS_CLK;
  always @(posedge SHIFT_CLOCK) edges++;
  assign SERIAL_IN_FROM_SLAVE = SLAVE_SELECT_N[1] ? miso[0] : miso[1];
  spi_master #(.NSLV(2)) i_spi_master (.SYS_CLK, .RESET_N, .ADDRESS, .READ, .WRITE, .WRITEDATA, .READDATA,
    .WAITREQUEST, .IRQ, .SHIFT_CLOCK, .SERIAL_OUT_TO_SLAVE, .SERIAL_IN_FROM_SLAVE, .SLAVE_SELECT_N);
  spi_slave_model i_spi_slave_model [1:0] (.sel_n(SLAVE_SELECT_N), .sclk(SHIFT_CLOCK),
    .mosi(SERIAL_OUT_TO_SLAVE), .cpol, .cpha, .bits, .base(32'h3C5A_A5C3), .miso, .got);
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // one avalon access, held until waitrequest is seen low
  task automatic bus(input logic [3:0] a, input logic w, input logic [31:0] d);
    ADDRESS <= a;
    WRITE <= w;
    READ <= !w;
    WRITEDATA <= d;
    @(posedge SYS_CLK);
    while (WAITREQUEST !== 1'b0) @(posedge SYS_CLK);
    q = READDATA;
    READ <= 1'b0;
    WRITE <= 1'b0;
    @(posedge SYS_CLK);
  endtask : bus
  // start one step and poll until the link is idle again
  task automatic step();
    bus(`REG_CTRL, 1'b1, ctrl | 32'h0000_1000);
    do bus(`REG_STATUS, 1'b0, 32'h0000_0000); while (q[`ST_BUSY_BIT] !== 1'b0);
  endtask : step
  task automatic give_verdict();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : give_verdict
  // the whole run needs well under 20k cycles
  initial begin
    #500_000;
    failures++;
    give_verdict();
  end
  initial begin
    repeat (20) @(posedge SYS_CLK);
    RESET_N <= 1'b1;
    @(posedge SYS_CLK);
    chk("sel", SLAVE_SELECT_N, 2'b11);
    bus(`REG_DIV, 1'b0, 32'h0000_0000);
    chk("div", q, `DIV_RESET);
    bus(`REG_WORDS, 1'b1, 32'h0000_0012);
    for (int k = 0; k < 3; k++) tw[k] = 32'h0000_9E37 + 32'(k) * 32'h0000_1111;
    // every mode, word length running down to one bit
    for (int m = 0; m < 4; m++) begin
      bits = 5'(16 - 5 * m);
      cpol = m[1];
      cpha = !m[0];
      mask = (32'h0000_0001 << bits) - 32'h0000_0001;
      ctrl = 32'(m) | (32'(bits - 5'd1) << 4) | 32'h0000_0100;
      bus(`REG_CTRL, 1'b1, ctrl);
      bus(`REG_STATUS, 1'b1, 32'h0000_0003);
      bus(`REG_RXDATA, 1'b1, 32'h0000_0000);
      for (int k = 0; k < 3; k++) bus(`REG_TXDATA, 1'b1, tw[k]);
      chk("idle clock", SHIFT_CLOCK, cpol);
      edges = 0;
      step();
      chk("pulses slave0", edges, 2 * bits);
      chk("valid early", q[`ST_VALID_BIT], 1'b0);
      chk("mosi slave0", got[15:0] & mask, tw[1] & mask);
      edges = 0;
      step();
      chk("pulses slave1", edges, bits);
      chk("valid", q[`ST_VALID_BIT], 1'b1);
      chk("mosi slave1", got[31:16] & mask, tw[2] & mask);
      // every mode reads back; each slave counts up from its base word
      bus(`REG_RXDATA, 1'b1, 32'h0000_0000);
      for (int k = 0; k < 3; k++) begin
        bus(`REG_RXDATA, 1'b0, 32'h0000_0000);
        chk("rx", q, (k < 2 ? 32'h0000_A5C3 + 32'(k) : 32'h0000_3C5A) & mask);
      end
    end
    // second step while busy: refused, overrun raised and routed to the interrupt
    bus(`REG_MASK, 1'b1, 32'h0000_0002);
    bus(`REG_CTRL, 1'b1, ctrl | 32'h0000_1000);
    step();
    chk("overrun", q[`ST_OVERRUN_BIT], 1'b1);
    chk("irq", IRQ, 1'b1);
    bus(`REG_MASK, 1'b1, 32'h0000_0000);
    chk("irq masked", IRQ, 1'b0);
    bus(`REG_STATUS, 1'b1, 32'h0000_0003);
    bus(`REG_STATUS, 1'b0, 32'h0000_0000);
    chk("cleared", q[1:0], 2'b00);
    give_verdict();
  end
endmodule : multi_slave_spi_master_tb
